// [src/srs_supply_ctrl.sv]
// Supply regulator and supervisor control with an AXI4-Lite register slave
`timescale 1ns/1ps
module srs_supply_ctrl #(
	parameter int ADDR_W = srs_pkg::ADDR_W
) (
	input  wire logic                 aclk,                  // System clock, 40 MHz
	input  wire logic                 aresetn,               // Synchronous reset, active low
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,          // Write address
	input  wire logic                 s_axi_awvalid,         // Write address valid
	output logic                      s_axi_awready,         // Write address ready
	input  wire logic [31:0]          s_axi_wdata,           // Write data
	input  wire logic [3:0]           s_axi_wstrb,           // Write byte strobes
	input  wire logic                 s_axi_wvalid,          // Write data valid
	output logic                      s_axi_wready,          // Write data ready
	output logic [1:0]                s_axi_bresp,           // Write response
	output logic                      s_axi_bvalid,          // Write response valid
	input  wire logic                 s_axi_bready,          // Write response ready
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,          // Read address
	input  wire logic                 s_axi_arvalid,         // Read address valid
	output logic                      s_axi_arready,         // Read address ready
	output logic [31:0]               s_axi_rdata,           // Read data
	output logic [1:0]                s_axi_rresp,           // Read response
	output logic                      s_axi_rvalid,          // Read data valid
	input  wire logic                 s_axi_rready,          // Read data ready
	input  wire srs_pkg::srs_sense_t  sense,                 // Raw analog comparator levels
	input  wire logic [3:0]           radio_mode_req,        // Radio subsystem mode request
	input  wire logic                 radio_regulator_req,   // Radio wants its regulator
	input  wire logic [2:0]           brownout_level_opt,    // Option: reset threshold
	input  wire logic [1:0]           bypass_level_opt,      // Option: bypass threshold
	output srs_pkg::srs_reg_cmd_t     reg_cmd,               // Regulator commands
	output logic                      step_down_converter_en, // 1 switching, 0 bypass
	output logic [1:0]                core_supply_level,     // Main regulator output range
	output logic                      brownout_supervisor_en, // Brown-out comparator on
	output logic [2:0]                brownout_level_select, // Reset threshold select
	output logic [1:0]                bypass_level_select,   // Bypass threshold select
	output logic                      supply_level_detector_en, // Detector comparator on
	output logic                      sys_reset_hold,        // System reset request
	output logic                      cpu_clk_limit,         // Clock capped at 2 MHz
	output logic                      radio_available,       // Radio may operate
	output srs_pkg::srs_pstate_t      power_state,           // Applied power state
	output logic                      irq                    // Level interrupt
);
	initial begin
		if (ADDR_W < 5 || ADDR_W > 16) begin
			$error("srs_supply_ctrl: ADDR_W out of range");
		end
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
		return (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2));
	endfunction : addr_is

	// Comparator synchronisers: two flops, then a third stage for edges
	localparam int NS = 4;
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	logic [NS-1:0] sync3;
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
					sync3[g] <= 1'b0;
				end else begin
					sync1[g] <= sense[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
				end
			end
		end
	endgenerate
	srs_pkg::srs_sense_t s_now;
	srs_pkg::srs_sense_t s_old;
	assign s_now = sync2;
	assign s_old = sync3;

	// Reset zeros in the sync stages would look like a crossing
	// Edges count only once both stages hold real samples
	logic [2:0] arm_sr;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arm_sr <= 3'h0;
		end else begin
			arm_sr <= {arm_sr[1:0], 1'b1};
		end
	end
	wire edge_ok = arm_sr[2];

	// Registers
	localparam int IRQ_W_L = srs_pkg::IRQ_W;
	logic [31:0]        ctrl;
	logic [IRQ_W_L-1:0] irq_sts;
	logic [IRQ_W_L-1:0] irq_en;

	// Write channel
	logic              aw_full;
	logic              w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	wire aw_take  = s_axi_awvalid & s_axi_awready;
	wire w_take   = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_full & w_full & ~s_axi_bvalid;
	wire wr_ctrl  = do_write & addr_is(aw_addr, srs_pkg::OFS_CTRL);
	wire wr_clr   = do_write & addr_is(aw_addr, srs_pkg::OFS_IRQ_CLR);
	wire wr_en    = do_write & addr_is(aw_addr, srs_pkg::OFS_IRQ_EN);
	wire wr_ro    = do_write & (addr_is(aw_addr, srs_pkg::OFS_STATUS)
		| addr_is(aw_addr, srs_pkg::OFS_IRQ_STS));
	wire wr_ok    = wr_ctrl | wr_clr | wr_en | wr_ro;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= srs_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			aw_full       <= do_write ? 1'b0 : (aw_full | aw_take);
			w_full        <= do_write ? 1'b0 : (w_full | w_take);
			s_axi_awready <= do_write | ~(aw_full | aw_take);
			s_axi_wready  <= do_write | ~(w_full | w_take);
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? srs_pkg::RESP_OKAY : srs_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Effective power state: the higher of the two requests
	wire [3:0] app_mode   = ctrl[srs_pkg::CTRL_MODE_LO +: 4];
	wire [3:0] want_mode  = (app_mode > radio_mode_req) ? app_mode : radio_mode_req;
	srs_pkg::srs_pstate_t next_state;
	always_comb begin
		case (want_mode)
			srs_pkg::MODE_SHUTDOWN: next_state = srs_pkg::PS_SHUTDOWN;
			srs_pkg::MODE_STANDBY:  next_state = srs_pkg::PS_STANDBY;
			srs_pkg::MODE_STBY_RET: next_state = srs_pkg::PS_STBY_RET;
			srs_pkg::MODE_STOP1:    next_state = srs_pkg::PS_STOP1;
			srs_pkg::MODE_STOP0:    next_state = srs_pkg::PS_STOP0;
			srs_pkg::MODE_LP_SLEEP: next_state = srs_pkg::PS_LP_SLEEP;
			srs_pkg::MODE_LP_RUN:   next_state = srs_pkg::PS_LP_RUN;
			srs_pkg::MODE_SLEEP:    next_state = srs_pkg::PS_SLEEP;
			// Undefined codes fall back to the safe full-power state
			default:                next_state = srs_pkg::PS_RUN;
		endcase
	end

	wire st_main = power_state[8] | power_state[7] | power_state[4];
	wire st_lp   = power_state[6] | power_state[5] | power_state[3] | power_state[2];
	wire st_off  = power_state[0] | power_state[1] | power_state[2];
	wire st_lpr  = power_state[6] | power_state[5];
	wire st_rad  = power_state[8] | power_state[7] | power_state[4] | power_state[3];
	// Bypass forcing is only serviced down to Stop 0
	wire force_ok = st_main | st_lpr;
	wire forced   = ctrl[srs_pkg::CTRL_SMART] & s_now.bypass_level_low & force_ok;

	// Detector events gated until software turns the detector on; PVM changes are not gated
	wire pvd_on   = ctrl[srs_pkg::CTRL_PVD_EN];
	wire pvd_fall = edge_ok & pvd_on & ctrl[srs_pkg::CTRL_PVD_FALL]
		& s_now.supply_below_pvd & ~s_old.supply_below_pvd;
	wire pvd_rise = edge_ok & pvd_on & ctrl[srs_pkg::CTRL_PVD_RISE]
		& ~s_now.supply_below_pvd & s_old.supply_below_pvd;
	wire pvm_chg  = edge_ok & (s_now.analog_supply_ok ^ s_old.analog_supply_ok);
	logic [IRQ_W_L-1:0] events;
	always_comb begin
		events = '0;
		events[srs_pkg::IRQ_PVD_FALL] = pvd_fall;
		events[srs_pkg::IRQ_PVD_RISE] = pvd_rise;
		events[srs_pkg::IRQ_PVM]      = pvm_chg;
	end
	wire [31:0] clr_word = merge_bytes(32'h0000_0000, w_data, w_strb);
	wire [IRQ_W_L-1:0] clr_bits = wr_clr ? clr_word[IRQ_W_L-1:0] : '0;
	// A new event beats a clear in the same cycle
	wire [IRQ_W_L-1:0] next_irq_sts = (irq_sts & ~clr_bits) | events;

	logic bo_loaded;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= srs_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= merge_bytes(ctrl, w_data, w_strb) & srs_pkg::CTRL_MASK;
		end
	end

	wire [31:0] en_word = merge_bytes(32'(irq_en), w_data, w_strb);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en <= '0;
		end else if (wr_en) begin
			irq_en <= en_word[IRQ_W_L-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sts <= '0;
		end else begin
			irq_sts <= next_irq_sts;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_state <= srs_pkg::PS_RUN;
			bo_loaded   <= 1'b0;
		end else begin
			power_state <= next_state;
			bo_loaded   <= 1'b1;
		end
	end

	// Regulator commands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_cmd <= '{main_regulator: 1'b1, default: 1'b0};
		end else begin
			reg_cmd.main_regulator      <= st_main;
			reg_cmd.low_power_regulator <= st_lp;
			reg_cmd.radio_regulator     <= radio_regulator_req & st_rad;
			reg_cmd.outputs_hiz         <= st_off;
		end
	end

	// Converter and core level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_down_converter_en <= 1'b0;
			core_supply_level      <= 2'h0;
		end else begin
			step_down_converter_en <= ctrl[srs_pkg::CTRL_SDC_EN] & ~forced;
			core_supply_level      <= ctrl[srs_pkg::CTRL_DVS_LO +: 2];
		end
	end

	// Supervisor enable and thresholds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brownout_supervisor_en <= 1'b1;
			brownout_level_select  <= srs_pkg::BO_LEVEL_POR;
			bypass_level_select    <= 2'h0;
		end else begin
			brownout_supervisor_en <= ~power_state[0];
			// Option levels take over only after the reset is released
			if (bo_loaded) begin
				brownout_level_select <= brownout_level_opt;
				bypass_level_select   <= bypass_level_opt;
			end
		end
	end

	// Detector power and reset hold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_level_detector_en <= 1'b0;
			sys_reset_hold           <= 1'b1;
		end else begin
			supply_level_detector_en <= pvd_on & ~st_off;
			sys_reset_hold           <= s_now.brownout_low;
		end
	end

	// Low-power run limits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_clk_limit   <= 1'b0;
			radio_available <= 1'b1;
		end else begin
			cpu_clk_limit   <= st_lpr;
			radio_available <= ~st_lpr;
		end
	end

	// Interrupt line tracks the status it will show
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_sts & irq_en);
		end
	end

	// Read channel
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[srs_pkg::ST_SDC_ON]  = step_down_converter_en;
		status_word[srs_pkg::ST_FORCED]  = forced;
		status_word[srs_pkg::ST_PVD_LOW] = s_now.supply_below_pvd;
		status_word[srs_pkg::ST_VDDA_OK] = s_now.analog_supply_ok;
		status_word[srs_pkg::ST_BO_LOW]  = s_now.brownout_low;
		status_word[srs_pkg::ST_MODE_LO +: 9] = power_state;
	end
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire rd_ctrl = addr_is(s_axi_araddr, srs_pkg::OFS_CTRL);
	wire rd_st   = addr_is(s_axi_araddr, srs_pkg::OFS_STATUS);
	wire rd_is   = addr_is(s_axi_araddr, srs_pkg::OFS_IRQ_STS);
	wire rd_clr  = addr_is(s_axi_araddr, srs_pkg::OFS_IRQ_CLR);
	wire rd_en   = addr_is(s_axi_araddr, srs_pkg::OFS_IRQ_EN);
	wire rd_ok   = rd_ctrl | rd_st | rd_is | rd_clr | rd_en;
	wire [31:0] rd_word = rd_ctrl ? ctrl
		: rd_st ? status_word
		: rd_is ? 32'(irq_sts)
		: rd_en ? 32'(irq_en)
		: 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= srs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? srs_pkg::RESP_OKAY : srs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : srs_supply_ctrl

// [src/srs_pkg.sv]
// Constants and types shared by the supply regulator supervisor
package srs_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_STATUS  = 5'h04;
	localparam logic [4:0] OFS_IRQ_STS = 5'h08;
	localparam logic [4:0] OFS_IRQ_CLR = 5'h0c;
	localparam logic [4:0] OFS_IRQ_EN  = 5'h10;
	// CTRL fields
	localparam int CTRL_SDC_EN   = 0;
	localparam int CTRL_SMART    = 1;
	localparam int CTRL_PVD_EN   = 2;
	localparam int CTRL_PVD_FALL = 3;
	localparam int CTRL_PVD_RISE = 4;
	localparam int CTRL_DVS_LO   = 6;
	localparam int CTRL_MODE_LO  = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0800;
	localparam logic [31:0] CTRL_MASK  = 32'h0000_0fdf;
	// STATUS fields
	localparam int ST_SDC_ON  = 0;
	localparam int ST_FORCED  = 1;
	localparam int ST_PVD_LOW = 2;
	localparam int ST_VDDA_OK = 3;
	localparam int ST_BO_LOW  = 4;
	localparam int ST_MODE_LO = 8;
	// Interrupt bits
	localparam int IRQ_W        = 3;
	localparam int IRQ_PVD_FALL = 0;
	localparam int IRQ_PVD_RISE = 1;
	localparam int IRQ_PVM      = 2;
	// Power mode codes, ordered so a larger code is a higher state
	localparam logic [3:0] MODE_SHUTDOWN = 4'h0;
	localparam logic [3:0] MODE_STANDBY  = 4'h1;
	localparam logic [3:0] MODE_STBY_RET = 4'h2;
	localparam logic [3:0] MODE_STOP1    = 4'h3;
	localparam logic [3:0] MODE_STOP0    = 4'h4;
	localparam logic [3:0] MODE_LP_SLEEP = 4'h5;
	localparam logic [3:0] MODE_LP_RUN   = 4'h6;
	localparam logic [3:0] MODE_SLEEP    = 4'h7;
	localparam logic [3:0] MODE_RUN      = 4'h8;
	localparam logic [2:0] BO_LEVEL_POR  = 3'h0;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	typedef enum logic [8:0] {
		PS_SHUTDOWN = 9'h001,
		PS_STANDBY  = 9'h002,
		PS_STBY_RET = 9'h004,
		PS_STOP1    = 9'h008,
		PS_STOP0    = 9'h010,
		PS_LP_SLEEP = 9'h020,
		PS_LP_RUN   = 9'h040,
		PS_SLEEP    = 9'h080,
		PS_RUN      = 9'h100
	} srs_pstate_t;
	typedef struct packed {
		logic main_regulator;
		logic low_power_regulator;
		logic radio_regulator;
		logic outputs_hiz;
	} srs_reg_cmd_t;
	typedef struct packed {
		logic supply_below_pvd;
		logic analog_supply_ok;
		logic brownout_low;
		logic bypass_level_low;
	} srs_sense_t;
endpackage : srs_pkg

// [test/srs_supply_ctrl_properties.sv]
// Port-level checks of the supply regulator supervisor
`timescale 1ns/1ps
module srs_ctrl_props (
	input wire logic                  aclk,                   // Clock
	input wire logic                  aresetn,                // Reset, low
	input wire srs_pkg::srs_sense_t   sense,                  // Comparators
	input wire logic [3:0]            radio_mode_req,         // Radio request
	input wire logic [2:0]            brownout_level_opt,     // Option level
	input wire srs_pkg::srs_reg_cmd_t reg_cmd,                // Regulators
	input wire logic                  step_down_converter_en, // Converter on
	input wire logic                  brownout_supervisor_en, // Supervisor on
	input wire logic [2:0]            brownout_level_select,  // Reset level
	input wire logic                  sys_reset_hold,         // Reset hold
	input wire logic                  cpu_clk_limit,          // Clock cap
	input wire logic                  radio_available,        // Radio usable
	input wire srs_pkg::srs_pstate_t  power_state             // Applied state
);
	wire logic [8:0] ps      = power_state;
	wire logic [8:0] req_hot = 9'h001 << ((radio_mode_req > 4'h8) ? 4'h8 : radio_mode_req);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Own disable: this one must hold while reset is applied
	property p_rst; disable iff (1'b0) !aresetn |=> !step_down_converter_en && brownout_level_select == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_main; |(ps & 9'h190) |=> reg_cmd.main_regulator; endproperty
	a_main: assert property (p_main) else $error("main regulator off");
	property p_lpr; |(ps & 9'h06c) |=> reg_cmd.low_power_regulator; endproperty
	a_lpr: assert property (p_lpr) else $error("low-power regulator off");
	property p_off; |(ps & 9'h003) |=> reg_cmd == 4'h1; endproperty
	a_off: assert property (p_off) else $error("regulators not powered down");
	property p_lprun; ps == 9'h040 |=> !reg_cmd.main_regulator && cpu_clk_limit && !radio_available; endproperty
	a_lprun: assert property (p_lprun) else $error("low-power run outputs wrong");
	property p_bo_en; brownout_supervisor_en == ($past(ps) != 9'h001); endproperty
	a_bo_en: assert property (p_bo_en) else $error("supervisor enable wrong");
	property p_hold; $stable(sense.brownout_low) [*5] |-> sys_reset_hold == sense.brownout_low; endproperty
	a_hold: assert property (p_hold) else $error("reset hold not following supply");
	property p_opt; $rose(aresetn) |-> ##1 brownout_level_select == srs_pkg::BO_LEVEL_POR ##1 brownout_level_select == brownout_level_opt; endproperty
	a_opt: assert property (p_opt) else $error("option level not loaded");
	property p_higher; 1'b1 |=> ps >= $past(req_hot); endproperty
	a_higher: assert property (p_higher) else $error("state below radio request");
endmodule : srs_ctrl_props
bind srs_supply_ctrl srs_ctrl_props u_props (.*);

// [test/srs_analog_model.sv]
// Behavioural supply comparators at the far side of the controller
`timescale 1ns/1ps
module srs_analog_model #(
	parameter int PVD_MV  = 2600, // Detector threshold, mV
	parameter int VDDA_MV = 1620, // Analog supply threshold, mV
	parameter int BOR_MV  = 1710, // Lowest reset threshold, mV
	parameter int STEP_MV = 100   // Spacing of higher levels, mV
) (
	input  wire logic [11:0]    vdd_mv,  // Main supply, mV
	input  wire logic [11:0]    vdda_mv, // Analog supply, mV
	input  wire logic           det_en,  // Detector powered
	input  wire logic           bo_en,   // Supervisor powered
	input  wire logic [2:0]     bo_sel,  // Reset level
	input  wire logic [1:0]     bp_sel,  // Bypass level
	output srs_pkg::srs_sense_t sense    // Comparator outputs
);
	// Unpowered comparators read low
	assign sense.supply_below_pvd = det_en && (vdd_mv < PVD_MV);
	assign sense.analog_supply_ok = vdda_mv >= VDDA_MV;
	assign sense.brownout_low     = bo_en && (vdd_mv < BOR_MV + STEP_MV * bo_sel);
	assign sense.bypass_level_low = vdd_mv < BOR_MV + STEP_MV * (bp_sel + 1);
endmodule : srs_analog_model

// [test/tb_srs_supply_ctrl.sv]
// Self-checking bench of the supply regulator supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_srs_supply_ctrl;
	typedef struct packed {
		logic [3:0] app;
		logic [3:0] radio;
		logic [8:0] state;
		logic [3:0] cmd;
		logic [2:0] misc;
	} srs_row_t;
	// Mode rows; misc is supervisor, clock cap, radio usable
	localparam srs_row_t ROWS [11] = '{
		'{4'h8, 4'h0, 9'h100, 4'h8, 3'h5}, '{4'h7, 4'h0, 9'h080, 4'h8, 3'h5},
		'{4'h6, 4'h0, 9'h040, 4'h4, 3'h6}, '{4'h5, 4'h0, 9'h020, 4'h4, 3'h6},
		'{4'h4, 4'h0, 9'h010, 4'h8, 3'h5}, '{4'h3, 4'h0, 9'h008, 4'h4, 3'h5},
		'{4'h2, 4'h0, 9'h004, 4'h5, 3'h5}, '{4'h1, 4'h0, 9'h002, 4'h1, 3'h5},
		'{4'h0, 4'h0, 9'h001, 4'h1, 3'h1}, '{4'h3, 4'h8, 9'h100, 4'h8, 3'h5},
		'{4'h0, 4'hf, 9'h100, 4'h8, 3'h5}};
	int                    num_errors = 0;
	int                    check_count = 0;
	logic                  aclk = 1'b0, aresetn = 1'b0, radio_regulator_req = 1'b0;
	logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic                  step_down_converter_en, brownout_supervisor_en, supply_level_detector_en;
	logic                  sys_reset_hold, cpu_clk_limit, radio_available;
	logic [4:0]            s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0]           s_axi_wdata = 32'h0000_0000, s_axi_rdata, q;
	logic [3:0]            s_axi_wstrb = 4'hf, radio_mode_req = 4'h0;
	logic [1:0]            s_axi_bresp, s_axi_rresp, core_supply_level, bypass_level_select, r;
	logic [1:0]            bypass_level_opt = 2'h1;
	logic [2:0]            brownout_level_opt = 3'h1, brownout_level_select;
	logic [11:0]           vdd_mv = 12'hbb8, vdda_mv = 12'hbb8;
	srs_pkg::srs_sense_t   sense;
	srs_pkg::srs_reg_cmd_t reg_cmd;
	srs_pkg::srs_pstate_t  power_state;
	srs_supply_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense, .radio_mode_req,
		.radio_regulator_req, .brownout_level_opt, .bypass_level_opt, .reg_cmd,
		.step_down_converter_en, .core_supply_level, .brownout_supervisor_en,
		.brownout_level_select, .bypass_level_select, .supply_level_detector_en,
		.sys_reset_hold, .cpu_clk_limit, .radio_available, .power_state, .irq);
	srs_analog_model model (.vdd_mv, .vdda_mv, .det_en(supply_level_detector_en),
		.bo_en(brownout_supervisor_en), .bo_sel(brownout_level_select),
		.bp_sel(bypass_level_select), .sense);
	initial forever #12.5 aclk = ~aclk;
	task automatic conclude;
		$display("errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	// Ready and valid are sampled at the falling edge, where they are settled
	task automatic axi(input logic wr, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] rq, output logic [1:0] rr);
		logic pa, pw, pr, ga, gw, gr;
		int n;
		pa = 1'b1;
		pw = wr;
		pr = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 40 && pr; n++) begin
			@(negedge aclk);
			ga = pa && (wr ? s_axi_awready : s_axi_arready);
			gw = pw && s_axi_wready;
			gr = wr ? s_axi_bvalid : s_axi_rvalid;
			rq = s_axi_rdata;
			rr = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ga) s_axi_awvalid <= 1'b0;
			if (ga) s_axi_arvalid <= 1'b0;
			if (gw) s_axi_wvalid <= 1'b0;
			if (gr) s_axi_bready <= 1'b0;
			if (gr) s_axi_rready <= 1'b0;
			pa = pa && !ga;
			pw = pw && !gw;
			pr = !gr;
		end
		if (pr) begin
			num_errors++;
			conclude();
		end
	endtask : axi
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
			input logic [1:0] e = srs_pkg::RESP_OKAY);
		axi(1'b1, a, d, q, r);
		`CHK(r, e)
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e,
			input logic [31:0] m = 32'hffff_ffff, input logic [1:0] er = srs_pkg::RESP_OKAY);
		axi(1'b0, a, 32'h0000_0000, q, r);
		`CHK(q & m, e)
		`CHK(r, er)
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : settle
	task automatic supply(input logic [11:0] v, input logic [11:0] va);
		@(posedge aclk);
		vdd_mv <= v;
		vdda_mv <= va;
	endtask : supply
	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset
	initial begin
		do_reset();
		settle(1);
		`CHK(reg_cmd, 4'h8)
		rd(srs_pkg::OFS_CTRL, srs_pkg::CTRL_RESET);
		rd(5'h14, 32'h0000_0000, 32'hffff_ffff, srs_pkg::RESP_SLVERR);
		wr(5'h14, 32'h0000_0801, srs_pkg::RESP_SLVERR);
		foreach (ROWS[i]) begin
			wr(srs_pkg::OFS_CTRL, 32'(ROWS[i].app) << 8);
			radio_mode_req <= ROWS[i].radio;
			settle(3);
			`CHK(power_state, ROWS[i].state)
			`CHK(reg_cmd, ROWS[i].cmd)
			`CHK({brownout_supervisor_en, cpu_clk_limit, radio_available}, ROWS[i].misc)
		end
		wr(srs_pkg::OFS_CTRL, 32'h0000_0881);
		radio_mode_req <= 4'h0;
		radio_regulator_req <= 1'b1;
		settle(3);
		`CHK(step_down_converter_en, 1'b1)
		`CHK(core_supply_level, 2'h2)
		`CHK(reg_cmd.radio_regulator, 1'b1)
		// 1880 mV lies between bypass levels zero and one
		wr(srs_pkg::OFS_CTRL, 32'h0000_0803);
		supply(12'h758, 12'hbb8);
		settle(6);
		`CHK(step_down_converter_en, 1'b0)
		rd(srs_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0003);
		supply(12'h640, 12'hbb8);
		settle(6);
		`CHK(sys_reset_hold, 1'b1)
		supply(12'h960, 12'hbb8);
		settle(6);
		`CHK({sys_reset_hold, irq}, 2'h0)
		`CHK(step_down_converter_en, 1'b1)
		wr(srs_pkg::OFS_IRQ_EN, 32'h0000_0007);
		supply(12'hbb8, 12'hbb8);
		wr(srs_pkg::OFS_CTRL, 32'h0000_081c);
		supply(12'h960, 12'hbb8);
		for (int n = 0; n < 20 && irq !== 1'b1; n++) @(negedge aclk);
		`CHK(irq, 1'b1)
		rd(srs_pkg::OFS_IRQ_STS, 32'h0000_0001, 32'h0000_0007);
		supply(12'hbb8, 12'hbb8);
		settle(6);
		rd(srs_pkg::OFS_IRQ_STS, 32'h0000_0003, 32'h0000_0007);
		wr(srs_pkg::OFS_IRQ_CLR, 32'h0000_0003);
		supply(12'hbb8, 12'h5dc);
		settle(6);
		rd(srs_pkg::OFS_IRQ_STS, 32'h0000_0004, 32'h0000_0007);
		rd(srs_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
		wr(srs_pkg::OFS_IRQ_EN, 32'h0000_0003);
		settle(2);
		`CHK(irq, 1'b0)
		wr(srs_pkg::OFS_IRQ_EN, 32'h0000_0004);
		settle(2);
		`CHK(irq, 1'b1)
		wr(srs_pkg::OFS_IRQ_CLR, 32'h0000_0004);
		settle(2);
		`CHK(irq, 1'b0)
		wr(srs_pkg::OFS_CTRL, 32'h0000_0801);
		do_reset();
		settle(0);
		`CHK({step_down_converter_en, brownout_level_select}, 4'h0)
		settle(3);
		`CHK(brownout_level_select, 3'h1)
		conclude();
	end
endmodule : tb_srs_supply_ctrl
